// [logic/frst_pkg.sv]
// Package with constants, types and the behaviour list of the fault report and self-test block.
// Behaviour
// - Enable regulators while logic enable or ignition enable is high.
// - Ignition enable status output follows the ignition enable input.
// - Power-good reset low while core, rail A or buck is out of regulation.
// - Fault flag low while any other fault exists.
// - On a fault, diagnostic output pulses with equal high and low times.
// - Diagnostic frequencies 102, 204, 409 and 512 kHz identify the fault.
// - Switch node or diode short to ground holds diagnostic output low.
// - Startup runs detector self-test; failures are readable over the bus.
// - Undervoltage test forces each comparator; a state change latches verify bit.
// - Undervoltage verification fails if any of seven verify bits is low.
// - Overvoltage test drives each comparator; a state change latches verify bit.
// - Overvoltage verification fails if any of seven verify bits is low.
// - Startup stimulates overtemperature; fault flag active and verify bit latched.
// - After overtemperature test fault flag clears; verify bit held until reset.
// - Compare sensed power-on enable with demand; mismatch flags fault, clears match.
// - Thermal shutdown turns regulators off and drives all fault outputs low.
package frst_pkg;
  localparam int          CLK_HZ        = 100_000_000;
  localparam int          FREQ_CP_HZ    = 102_000;
  localparam int          FREQ_PRE_HZ   = 204_000;
  localparam int          FREQ_DIO_HZ   = 409_000;
  localparam int          FREQ_BUCK_HZ  = 512_000;
  // Half period in cycles, rounded down.
  localparam logic [9:0]  HALF_CP       = 10'(CLK_HZ / (2 * FREQ_CP_HZ));
  localparam logic [9:0]  HALF_PRE      = 10'(CLK_HZ / (2 * FREQ_PRE_HZ));
  localparam logic [9:0]  HALF_DIO      = 10'(CLK_HZ / (2 * FREQ_DIO_HZ));
  localparam logic [9:0]  HALF_BUCK     = 10'(CLK_HZ / (2 * FREQ_BUCK_HZ));
  localparam int          NRAIL         = 7;
  localparam logic [3:0]  TEST_WAIT     = 4'hF;
  // Bit order of the seven tested rails.
  localparam int          RAIL_PRE      = 0;
  localparam int          RAIL_CORE     = 1;
  localparam int          RAIL_A        = 2;
  localparam int          RAIL_B        = 3;
  localparam int          RAIL_PROT     = 4;
  localparam int          RAIL_XCVR     = 5;
  localparam int          RAIL_BUCK     = 6;
  // APB map.
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_VERIFY0  = 12'h008;
  localparam logic [11:0] ADDR_VERIFY1  = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;
  localparam logic [3:0]  IRQ_RESET     = 4'h0;
  localparam logic        CTRL_RESET    = 1'b1;
  // Interrupt event bits.
  localparam int          EV_DONE       = 0;
  localparam int          EV_FAIL       = 1;
  localparam int          EV_FAULT      = 2;
  localparam int          EV_MISMATCH   = 3;

  typedef enum logic [2:0] {ST_UV, ST_OV, ST_OT, ST_DONE} frst_state_type;

  typedef struct packed {
    logic [NRAIL-1:0] uv;
    logic [NRAIL-1:0] ov;
    logic             cp_ov;
    logic             pre_ov2;
    logic             diode_open;
    logic             short_gnd;
    logic             other;
    logic             overtemp;
  } frst_det_type;

  typedef struct packed {
    logic [NRAIL-1:0] uv;
    logic [NRAIL-1:0] ov;
    logic             overtemp;
  } frst_stim_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } frst_apb_req_type;

  typedef struct packed {
    frst_state_type   state;
    logic [3:0]       wait_cnt;
    logic [2:0]       rail;
    logic [NRAIL-1:0] uv_ver;
    logic [NRAIL-1:0] ov_ver;
    logic             ot_ver;
    logic             test_flag;
    logic             done;
    logic             poe_demand;
    logic             poe_out;
    logic             match;
    logic [9:0]       div_cnt;
    logic             fault_code_pulse_out;
    logic             reg_en;
    logic             ign_stat;
    logic             pgood_n;
    logic             fault_n;
    logic             en_ctrl;
    logic [3:0]       irq_stat;
    logic [3:0]       irq_mask;
    logic             irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } frst_state_all_type;
endpackage : frst_pkg

// [logic/frst_top.sv]
// Fault reporting, startup self-test and enable logic with an APB register slave.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ns
module frst_top
  import frst_pkg::*;
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_logic_enable_in,
  input  wire logic             i_ignition_enable_in,
  input  wire frst_det_type     i_det,
  input  wire logic             i_power_on_enable_sense,
  input  wire logic             i_power_on_enable_request,
  input  wire frst_apb_req_type i_apb,
  output logic                  o_regulator_enable,
  output logic                  o_ignition_enable_status,
  output logic                  o_power_good_reset_n,
  output logic                  o_fault_flag_n,
  output logic                  o_fault_code_pulse_out,
  output logic                  o_power_on_enable_out,
  output frst_stim_type         o_stim,
  output logic                  o_irq,
  output logic                  o_pready,
  output logic                  o_pslverr,
  output logic [31:0]           o_prdata
);
  frst_state_all_type r;
  frst_state_all_type next_r;
  frst_stim_type      stim;
  frst_det_type       det_q;

  function automatic logic [9:0] half_period(input frst_det_type d);
    if (d.cp_ov) begin
      half_period = HALF_CP;
    end else if (d.pre_ov2) begin
      half_period = HALF_PRE;
    end else if (d.diode_open) begin
      half_period = HALF_DIO;
    end else begin
      half_period = HALF_BUCK;
    end
  endfunction : half_period

  logic overtemp_shutdown;
  logic code_fault;
  logic any_fault;
  logic pg_bad;
  logic wr;
  logic rd;
  logic [3:0] events;
  logic [31:0] rdata;
  logic        addr_ok;

  assign overtemp_shutdown = i_det.overtemp & (r.state == ST_DONE);
  assign code_fault = i_det.cp_ov | i_det.pre_ov2 | i_det.diode_open | i_det.ov[RAIL_BUCK];
  assign pg_bad = r.done & (i_det.uv[RAIL_CORE] | i_det.ov[RAIL_CORE] | i_det.uv[RAIL_A]
                  | i_det.ov[RAIL_A] | i_det.uv[RAIL_BUCK] | i_det.ov[RAIL_BUCK]);
  assign any_fault = r.test_flag | !r.match | (r.done & (code_fault | i_det.short_gnd
                     | i_det.other | (|i_det.uv) | (|i_det.ov)));
  assign wr = i_apb.psel & i_apb.penable & i_apb.pwrite;
  assign rd = i_apb.psel & !i_apb.penable & !i_apb.pwrite;
  assign det_q = i_det;

  always_comb begin
    stim = '0;
    if (r.state == ST_UV) begin
      stim.uv[r.rail] = 1'b1;
    end
    if (r.state == ST_OV) begin
      stim.ov[r.rail] = 1'b1;
    end
    stim.overtemp = (r.state == ST_OT);
  end

  always_comb begin
    addr_ok = 1'b1;
    case (i_apb.paddr)
      ADDR_CTRL:     rdata = {31'h0, r.en_ctrl};
      ADDR_STATUS:   rdata = {26'h0, !(r.uv_ver == '1 && r.ov_ver == '1 && r.ot_ver),
                              r.done, r.match, r.poe_demand, r.test_flag, overtemp_shutdown};
      ADDR_VERIFY0:  rdata = {23'h0, r.ov_ver[0], r.uv_ver, r.ot_ver};
      ADDR_VERIFY1:  rdata = {26'h0, r.ov_ver[NRAIL-1:1]};
      ADDR_IRQ_STAT: rdata = {28'h0, r.irq_stat};
      ADDR_IRQ_MASK: rdata = {28'h0, r.irq_mask};
      default: begin
        rdata = 32'h0;
        addr_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_r = r;
    events = '0;
    // Test sequence: one rail at a time, each held for 16 cycles while a set detector bit is latched.
    case (r.state)
      ST_UV, ST_OV: begin
        if (r.state == ST_UV && det_q.uv[r.rail]) begin
          next_r.uv_ver[r.rail] = 1'b1;
        end
        if (r.state == ST_OV && det_q.ov[r.rail]) begin
          next_r.ov_ver[r.rail] = 1'b1;
        end
        next_r.wait_cnt = r.wait_cnt + 4'h1;
        if (r.wait_cnt == TEST_WAIT) begin
          next_r.wait_cnt = '0;
          next_r.rail = r.rail + 3'h1;
          if (r.rail == 3'(NRAIL - 1)) begin
            next_r.rail = '0;
            next_r.state = (r.state == ST_UV) ? ST_OV : ST_OT;
          end
        end
      end
      ST_OT: begin
        next_r.test_flag = 1'b1;
        if (det_q.overtemp) begin
          next_r.ot_ver = 1'b1;
        end
        next_r.wait_cnt = r.wait_cnt + 4'h1;
        if (r.wait_cnt == TEST_WAIT) begin
          next_r.test_flag = 1'b0;
          next_r.done = 1'b1;
          next_r.state = ST_DONE;
          events[EV_DONE] = 1'b1;
          // Verify fails if any bit is still low after the sequence.
          events[EV_FAIL] = !(r.uv_ver == '1 && r.ov_ver == '1
                              && (r.ot_ver | det_q.overtemp));
        end
      end
      ST_DONE: next_r.state = ST_DONE;
      default: next_r.state = ST_UV;
    endcase

    next_r.poe_demand = i_power_on_enable_request & !pg_bad & !overtemp_shutdown;
    next_r.poe_out = next_r.poe_demand & !overtemp_shutdown;
    next_r.match = (i_power_on_enable_sense == r.poe_out);
    events[EV_MISMATCH] = r.match & !next_r.match;

    // Diagnostic pulse train: toggles every half period of the selected code.
    if (overtemp_shutdown || (r.done && i_det.short_gnd) || !(r.done && code_fault)) begin
      next_r.fault_code_pulse_out = 1'b0;
      next_r.div_cnt = '0;
    end else if (r.div_cnt >= half_period(i_det) - 10'h1) begin
      next_r.div_cnt = '0;
      next_r.fault_code_pulse_out = !r.fault_code_pulse_out;
    end else begin
      next_r.div_cnt = r.div_cnt + 10'h1;
    end

    next_r.reg_en = r.en_ctrl & (i_logic_enable_in | i_ignition_enable_in) & !overtemp_shutdown;
    next_r.ign_stat = i_ignition_enable_in;
    next_r.pgood_n = !(pg_bad | overtemp_shutdown);
    next_r.fault_n = !(any_fault | overtemp_shutdown);
    events[EV_FAULT] = r.fault_n & !next_r.fault_n;

    // APB: one wait-free access, pready in the access phase.
    next_r.pready = rd | (i_apb.psel & !i_apb.penable & i_apb.pwrite);
    next_r.pslverr = next_r.pready & !addr_ok;
    if (rd) begin
      next_r.prdata = rdata;
    end
    if (wr && r.pready && addr_ok) begin
      if (i_apb.paddr == ADDR_CTRL) begin
        next_r.en_ctrl = i_apb.pwdata[0];
      end
      if (i_apb.paddr == ADDR_IRQ_MASK) begin
        next_r.irq_mask = i_apb.pwdata[3:0];
      end
      if (i_apb.paddr == ADDR_IRQ_STAT) begin
        next_r.irq_stat = r.irq_stat & ~i_apb.pwdata[3:0];
      end
    end
    next_r.irq_stat = next_r.irq_stat | events;
    // A set mask bit hides its status bit from the interrupt line.
    next_r.irq = |(next_r.irq_stat & ~next_r.irq_mask);
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r          <= '0;
      r.state    <= ST_UV;
      r.match    <= 1'b1;
      r.pgood_n  <= 1'b0;
      r.fault_n  <= 1'b1;
      r.en_ctrl  <= CTRL_RESET;
      r.irq_mask <= IRQ_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign o_regulator_enable       = r.reg_en;
  assign o_ignition_enable_status = r.ign_stat;
  assign o_power_good_reset_n     = r.pgood_n;
  assign o_fault_flag_n           = r.fault_n;
  assign o_fault_code_pulse_out   = r.fault_code_pulse_out;
  assign o_power_on_enable_out    = r.poe_out;
  assign o_stim                   = stim;
  assign o_irq                    = r.irq;
  assign o_pready                 = r.pready;
  assign o_pslverr                = r.pslverr;
  assign o_prdata                 = r.prdata;

  logic       cp_prev;
  logic [9:0] cp_len;

  // Length of the current high half of the charge pump code, counted only from a rising edge,
  // so that a high run begun under another code is not judged.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cp_prev <= 1'b0;
      cp_len  <= 10'h000;
    end else begin
      cp_prev <= r.fault_code_pulse_out;
      if (!(r.done && i_det.cp_ov && !overtemp_shutdown && !i_det.short_gnd) || !r.fault_code_pulse_out) begin
        cp_len <= 10'h000;
      end else if (!cp_prev) begin
        cp_len <= 10'h001;
      end else if (cp_len != 10'h000) begin
        cp_len <= cp_len + 10'h001;
      end
    end
  end

  // The first edge after reset release still shows reset values, so checks start one edge later.
  property p_ign_follow;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      i_nrst |=> o_ignition_enable_status == $past(i_ignition_enable_in);
  endproperty
  AST_IGN_FOLLOW: assert property (p_ign_follow)
    else $error("status not following input");

  AST_ENABLE: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_nrst && r.en_ctrl && i_logic_enable_in && !overtemp_shutdown) |=> o_regulator_enable)
    else $error("regulators not enabled");

  AST_TSD_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    overtemp_shutdown |=> (!o_regulator_enable && !o_power_good_reset_n && !o_fault_flag_n
             && !o_fault_code_pulse_out && !o_power_on_enable_out))
    else $error("thermal shutdown outputs wrong");

  AST_PGOOD: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    pg_bad |=> !o_power_good_reset_n) else $error("power good not low");

  AST_SHORT_LOW: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (r.done && i_det.short_gnd) |=> !o_fault_code_pulse_out)
    else $error("fault_code_pulse_out not low on short");

  sequence s_cp_fault;
    r.done && i_det.cp_ov && !overtemp_shutdown && !i_det.short_gnd;
  endsequence
  AST_CP_HALF: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (s_cp_fault ##0 (cp_len == HALF_CP)) |-> !r.fault_code_pulse_out)
    else $error("fault_code_pulse_out high longer than half period");

  AST_CP_FULL: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (s_cp_fault ##0 (cp_len != 10'h000 && cp_len < HALF_CP)) |-> r.fault_code_pulse_out)
    else $error("fault_code_pulse_out high shorter than half period");

  AST_MISMATCH: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_power_on_enable_sense != r.poe_out) |=> (!r.match ##1 !o_fault_flag_n))
    else $error("mismatch not flagged");

  AST_VER_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $rose(r.ot_ver) |=> r.ot_ver [*8]) else $error("verify bit lost");

  AST_UV_LATCH: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_nrst && r.state == ST_UV && i_det.uv[r.rail]) |=> r.uv_ver[$past(r.rail)])
    else $error("uv verify not latched");

  AST_OV_LATCH: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (r.state == ST_OV && i_det.ov[r.rail]) |=> r.ov_ver[$past(r.rail)])
    else $error("ov verify not latched");

  AST_OT_FLAG: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (r.state == ST_OT && r.test_flag) |=> !o_fault_flag_n || r.done)
    else $error("test fault flag not shown");
endmodule : frst_top

// [test/frst_partner.sv]
// Detector and power-on enable pin model seen by the fault block.
`timescale 1ns/1ns
module frst_partner
  import frst_pkg::*;
(
  input  wire logic          i_sys_clk,
  input  wire logic          i_nrst,
  input  wire frst_stim_type i_stim,
  input  wire frst_det_type  i_flt,
  input  wire logic [6:0]    i_skip,
  input  wire logic          i_poe,
  input  wire logic          i_brk,
  output frst_det_type       o_det,
  output logic               o_sense
);
  logic brk_q;
  // Detectors trip on the test stimulus, except undervoltage detectors of rails marked broken.
  always_comb begin
    o_det          = i_flt;
    o_det.uv       = i_flt.uv | (i_stim.uv & ~i_skip);
    o_det.ov       = i_flt.ov | i_stim.ov;
    o_det.overtemp = i_flt.overtemp | i_stim.overtemp;
  end
  // The sensed pin follows the driven enable; a break, one cycle after it is asked for, inverts it.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      brk_q <= 1'h0;
    end else begin
      brk_q <= i_brk;
    end
  end
  assign o_sense = i_poe ^ brk_q;
endmodule : frst_partner

// [test/fault_report_selftest_tb_top.sv]
// Self-checking bench for the fault report and self-test block.
`timescale 1ns/1ns
module fault_report_selftest_tb_top;
  import frst_pkg::*;
  logic             clk  = 1'h0;
  logic             nrst = 1'h0;
  logic             el   = 1'h0;
  logic             ei   = 1'h0;
  logic             brk  = 1'h0;
  logic [6:0]       skip = 7'h00;
  frst_det_type     flt  = '0;
  frst_apb_req_type apb  = '0;
  frst_det_type     det;
  frst_stim_type    stim;
  logic             sense, ren, ist, pg_n, ff_n, fault_code_pulse_out, power_on_enable_out, irq, prdy, perr, er;
  logic [31:0]      prd, rd;
  int               mismatches  = 0;
  int               check_count = 0;
  int               hi, lo;
  frst_det_type     f;
  always #5 clk = ~clk;
  frst_partner u_far (.i_sys_clk(clk), .i_nrst(nrst), .i_stim(stim), .i_flt(flt),
    .i_skip(skip), .i_poe(power_on_enable_out), .i_brk(brk), .o_det(det), .o_sense(sense));
  frst_top dut (.i_sys_clk(clk), .i_nrst(nrst), .i_logic_enable_in(el),
    .i_ignition_enable_in(ei), .i_det(det), .i_power_on_enable_sense(sense),
    .i_power_on_enable_request(1'h1), .i_apb(apb), .o_regulator_enable(ren),
    .o_ignition_enable_status(ist), .o_power_good_reset_n(pg_n), .o_fault_flag_n(ff_n),
    .o_fault_code_pulse_out(fault_code_pulse_out), .o_power_on_enable_out(power_on_enable_out), .o_stim(stim),
    .o_irq(irq), .o_pready(prdy), .o_pslverr(perr), .o_prdata(prd));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic give_up;
    mismatches++;
    wrap_up();
  endtask : give_up
  task automatic cw(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : cw
  task automatic cb(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask : cb
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    apb.psel    <= 1'h1;
    apb.penable <= 1'h0;
    apb.pwrite  <= w;
    apb.paddr   <= a;
    apb.pwdata  <= d;
    @(posedge clk);
    apb.penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'h1 && n < 20);
    if (n >= 20) give_up();
    rd = prd;
    er = perr;
    apb.psel    <= 1'h0;
    apb.penable <= 1'h0;
  endtask : bus
  function automatic int half(input int k);
    case (k)
      0: return HALF_CP;
      1: return HALF_PRE;
      2: return HALF_DIO;
      default: return HALF_BUCK;
    endcase
  endfunction : half
  function automatic logic pg_bad(input frst_det_type d);
    return |({d.uv, d.ov} & {7'h46, 7'h46});
  endfunction : pg_bad
  task automatic start(input logic [6:0] sk);
    int n;
    @(posedge clk);
    nrst <= 1'h0;
    skip <= sk;
    tick(20);
    nrst <= 1'h1;
    n = 0;
    do begin
      bus(1'h0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd[4] !== 1'h1 && n < 200);
    if (n >= 200) give_up();
    cb("verify fail", |sk, rd[5]);
    cb("test flag", 1'h0, rd[1]);
    bus(1'h0, ADDR_VERIFY0, 32'h0);
    cw("verify0", {23'h0, 1'h1, ~sk, 1'h1}, rd);
    bus(1'h0, ADDR_VERIFY1, 32'h0);
    cw("verify1", 32'h3F, rd);
    bus(1'h0, ADDR_IRQ_STAT, 32'h0);
    cw("irq status", {29'h0, 1'h1, |sk, 1'h1}, rd & 32'h7);
    $display("selftest run done");
  endtask : start
  task automatic measure;
    int n;
    n = 0;
    while (fault_code_pulse_out !== 1'h0 && n < 3000) begin @(posedge clk); n++; end
    while (fault_code_pulse_out !== 1'h1 && n < 3000) begin @(posedge clk); n++; end
    hi = 0;
    lo = 0;
    while (fault_code_pulse_out === 1'h1 && hi < 3000) begin @(posedge clk); hi++; end
    while (fault_code_pulse_out === 1'h0 && lo < 3000) begin @(posedge clk); lo++; end
    if (n >= 3000 || hi >= 3000 || lo >= 3000) give_up();
  endtask : measure
  initial begin
    void'($urandom(5132));
    start(7'h00);
    cb("irq on", 1'h1, irq);
    bus(1'h1, ADDR_IRQ_MASK, 32'hF);
    tick(2);
    cb("irq masked", 1'h0, irq);
    bus(1'h1, ADDR_IRQ_MASK, 32'h0);
    tick(2);
    cb("irq unmasked", 1'h1, irq);
    bus(1'h1, ADDR_IRQ_STAT, 32'hF);
    tick(2);
    cb("irq cleared", 1'h0, irq);
    for (int i = 0; i < 10; i++) begin
      el <= 1'($urandom);
      ei <= 1'($urandom);
      tick(3);
      cb("regulator enable", el | ei, ren);
      cb("ignition status", ei, ist);
    end
    $display("enable test done");
    for (int i = 0; i < 12; i++) begin
      f = '0;
      if (i % 3 != 0) begin
        f.uv    = 7'($urandom & $urandom);
        f.ov    = 7'($urandom & $urandom & $urandom);
        f.other = 1'($urandom);
      end
      flt <= f;
      tick(4);
      cb("power good", ~pg_bad(f), pg_n);
      cb("fault flag", ~(|f.uv | |f.ov | f.other), ff_n);
    end
    $display("rail fault test done");
    for (int k = 0; k < 4; k++) begin
      f = '0;
      f.cp_ov          = (k == 0);
      f.pre_ov2        = (k == 1);
      f.diode_open     = (k < 3);
      f.ov[RAIL_BUCK]  = (k == 3);
      flt <= f;
      tick(2);
      measure();
      cw("fault_code_pulse_out high", half(k), hi);
      cw("fault_code_pulse_out low", half(k), lo);
    end
    f.short_gnd = 1'h1;
    f.cp_ov     = 1'h1;
    flt <= f;
    tick(3);
    hi = 0;
    repeat (1200) begin @(posedge clk); if (fault_code_pulse_out !== 1'h0) hi++; end
    cw("fault_code_pulse_out short", 32'h0, hi);
    $display("fault_code_pulse_out test done");
    flt <= '0;
    tick(4);
    brk <= 1'h1;
    el  <= 1'h1;
    tick(4);
    cb("mismatch flag", 1'h0, ff_n);
    bus(1'h0, ADDR_STATUS, 32'h0);
    cb("enable match", 1'h0, rd[3]);
    f = '0;
    f.overtemp = 1'h1;
    flt <= f;
    tick(4);
    cw("shutdown outputs", 32'h0, {27'h0, ren, pg_n, ff_n, power_on_enable_out, fault_code_pulse_out});
    flt <= '0;
    brk <= 1'h0;
    bus(1'h1, 12'h0FC, 32'hFFFF_FFFF);
    cb("write error", 1'h1, er);
    bus(1'h0, 12'h0FC, 32'h0);
    cb("read error", 1'h1, er);
    cw("unmapped data", 32'h0, rd);
    $display("protection test done");
    start(7'h08);
    wrap_up();
  end
  initial begin
    tick(100000);
    give_up();
  end
endmodule : fault_report_selftest_tb_top
